// ===== fbs_fieldbus_partner.sv
/*
 Far side model: non-volatile alias store and the clock sync pulse of the master.
 Assumes the block's alias store ports and one ref_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module fbs_fieldbus_partner #(
   // Much shorter than the real minimum cycle so that several cycles fit in a run.
   parameter int unsigned SYNC_PERIOD = 100,
   parameter logic [15:0] ALIAS_INIT  = 16'h5a3c
) (
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // Alias store.
   input  wire logic [15:0] aliasNvOut,
   input  wire logic        aliasNvWrite,
   output logic [15:0]      aliasNvIn,
   // Sync.
   output logic             syncPulse
);
   // Safety watchdog time the master configures; never below the minimum.
   localparam int unsigned SAFETY_WD_MS = 35;
   // The master assigns the station address itself; no switch input exists.
   logic [15:0] aliasStore_r = ALIAS_INIT;
   logic [7:0]  syncCnt_r;
   logic [7:0]  syncCnt_nxt;
   // The store has no reset, as it must survive a reset of the block.
   always @(posedge ref_clk) begin
      if (aliasNvWrite) aliasStore_r <= aliasNvOut;
   end
   always_comb begin
      syncCnt_nxt = (syncCnt_r == 8'(SYNC_PERIOD - 1)) ? 8'h00 : syncCnt_r + 8'h01;
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) syncCnt_r <= 8'h00;
      else syncCnt_r <= syncCnt_nxt;
   end
   assign aliasNvIn = aliasStore_r;
   assign syncPulse = syncCnt_r >= 8'h04 && syncCnt_r < 8'h0c;
endmodule : fbs_fieldbus_partner
`default_nettype wire

// ===== fbs_pkg.sv
/*
 Package for the fieldbus slave status indication block: register map, field
 layouts, capability limits, LED timing and enumerations.
 Assumes a single 250 MHz clock domain and an APB register bus.
*/
package fbs_pkg;
   localparam int unsigned CLK_HZ        = 250_000_000;
   localparam int unsigned SLOT_FAST_MS  = 50;
   localparam int unsigned SLOT_SLOW_MS  = 200;
   localparam int unsigned FAST_CYC      = CLK_HZ / 1000 * SLOT_FAST_MS;
   localparam int unsigned SLOW_CYC      = CLK_HZ / 1000 * SLOT_SLOW_MS;
   localparam int unsigned FLICK_MS      = 50;
   localparam int unsigned FLICK_CYC     = CLK_HZ / 1000 * FLICK_MS;
   localparam int unsigned ACT_HOLD_MS   = 100;
   localparam int unsigned ACT_HOLD_CYC  = CLK_HZ / 1000 * ACT_HOLD_MS;
   localparam int unsigned CNT_W         = 26;

   // Capability limits.
   localparam logic [3:0]  NUM_SYNC_MGR      = 4'h4;
   localparam logic [3:0]  NUM_MAP_UNIT      = 4'h3;
   localparam logic [3:0]  MAX_PDO_PER_DIR   = 4'h2;
   localparam logic [7:0]  PD_BYTES_BASE     = 8'h20;
   localparam logic [7:0]  PD_BYTES_EXT      = 8'h40;
   localparam logic [7:0]  DC_TIME_BITS      = 8'h20;
   localparam logic [15:0] SYNC_MIN_US_BASE  = 16'h01f4;
   localparam logic [15:0] SYNC_MIN_US_EXT   = 16'h00fa;
   localparam logic [7:0]  SYNC_MULT_BASE    = 8'h08;
   localparam logic [7:0]  SYNC_MULT_EXT     = 8'h04;
   localparam logic [15:0] SAFETY_WD_MIN_MS  = 16'h0023;
   localparam logic [7:0]  IDENT_FIELD_NUM   = 8'h86;
   localparam logic [3:0]  MBX_SERVICES      = 4'h7;
   localparam logic [3:0]  SM_ROLE_RXMBX     = 4'h0;
   localparam logic [3:0]  SM_ROLE_TXMBX     = 4'h1;
   localparam logic [3:0]  SM_ROLE_OUTPD     = 4'h2;
   localparam logic [3:0]  SM_ROLE_INPD      = 4'h3;

   // Register byte addresses.
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_ALIAS    = 8'h08;
   localparam logic [7:0] ADDR_CAP0     = 8'h0c;
   localparam logic [7:0] ADDR_CAP1     = 8'h10;
   localparam logic [7:0] ADDR_CAP2     = 8'h14;
   localparam logic [7:0] ADDR_MBX_REQ  = 8'h18;
   localparam logic [7:0] ADDR_MBX_RSP  = 8'h1c;
   localparam logic [7:0] ADDR_SLAVEST  = 8'h20;

   // Control register fields.
   localparam int unsigned CTRL_EXT_FW   = 0;
   localparam int unsigned CTRL_SYNC_EN  = 1;
   localparam int unsigned CTRL_SAFETY   = 2;
   // Slave status register fields.
   localparam int unsigned SST_STATE_LO  = 0;
   localparam int unsigned SST_COMM_ERR  = 4;
   localparam int unsigned SST_LOAD_ERR  = 5;
   localparam int unsigned SST_CFG_ERR   = 6;
   localparam int unsigned SST_WARN      = 7;
   localparam int unsigned SST_LOCAL_ERR = 8;
   localparam int unsigned SST_WDOG      = 9;

   // Mailbox service codes.
   localparam logic [3:0] MBX_DOWNLOAD  = 4'h1;
   localparam logic [3:0] MBX_UPLOAD    = 4'h2;
   localparam logic [3:0] MBX_EMERGENCY = 4'h3;
   localparam logic [1:0] MBX_RSP_OK    = 2'h1;
   localparam logic [1:0] MBX_RSP_UNSUP = 2'h2;

   localparam logic [3:0] ST_INIT    = 4'h1;
   localparam logic [3:0] ST_PREOP   = 4'h2;
   localparam logic [3:0] ST_SAFEOP  = 4'h4;
   localparam logic [3:0] ST_OP      = 4'h8;

   localparam int unsigned NUM_PORTS = 2;

   typedef enum logic [3:0] {
      PAT_OFF, PAT_G_FAST, PAT_G_SAFEOP, PAT_G_ON, PAT_R_ON, PAT_R_LOAD,
      PAT_R_CFG, PAT_R_SINGLE, PAT_R_DOUBLE
   } fbs_pat_e;
endpackage : fbs_pkg

// ===== fbs_status_led.sv
/*
 Status indication and capability logic of the fieldbus slave: network status
 LED pattern generator, per-port link LEDs, capability words, alias store and
 mailbox service check; the last three are reached over APB.
 Assumes slave state and error inputs come from logic on ref_clk, and link and
 sync inputs come from pins and are synchronised here.
*/
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fbs_status_led
   import fbs_pkg::*;
(
   // Clock and reset.
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   // APB slave.
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   // Slave state and errors from the protocol core.
   input  wire logic [3:0]           slaveState,
   input  wire logic                 commErr,
   input  wire logic                 loadErr,
   input  wire logic                 cfgErr,
   input  wire logic                 warnLevel,
   input  wire logic                 localDrop,
   input  wire logic                 wdogTimeout,
   // Pins.
   input  wire logic [NUM_PORTS-1:0] portOpen,
   input  wire logic [NUM_PORTS-1:0] portActivity,
   input  wire logic                 syncPulse,
   // Alias non-volatile store.
   input  wire logic [15:0]          aliasNvIn,
   output logic [15:0]               aliasNvOut,
   output logic                      aliasNvWrite,
   // Indicators and timing.
   output logic                      netLedGreen,
   output logic                      netLedRed,
   output logic [NUM_PORTS-1:0]      linkLedGreen,
   output logic [NUM_PORTS-1:0]      linkLedYellow,
   output logic                      errorBit,
   output logic                      gridAlign
);
   localparam int unsigned PW = NUM_PORTS;

   // Pin synchronisers.
   logic [PW-1:0] openS1_r, openS2_r, actS1_r, actS2_r;
   logic          syncS1_r, syncS2_r, syncS3_r;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         openS1_r <= '0;
         openS2_r <= '0;
         actS1_r  <= '0;
         actS2_r  <= '0;
         syncS1_r <= 1'b0;
         syncS2_r <= 1'b0;
         syncS3_r <= 1'b0;
      end else begin
         openS1_r <= portOpen;
         openS2_r <= openS1_r;
         actS1_r  <= portActivity;
         actS2_r  <= actS1_r;
         syncS1_r <= syncPulse;
         syncS2_r <= syncS1_r;
         syncS3_r <= syncS2_r;
      end
   end

   // Register state.
   logic [2:0]  ctrl_r, ctrl_nxt;
   logic [15:0] alias_r, alias_nxt;
   logic        aliasLoaded_r, aliasLoaded_nxt;
   logic        nvWr_r, nvWr_nxt;
   logic [1:0]  mbxRsp_r, mbxRsp_nxt;
   logic        errBit_r, errBit_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        ready_r, ready_nxt;
   logic        slverr_r, slverr_nxt;
   logic        gridAlign_r, gridAlign_nxt;

   logic        apbAccess;
   logic        addrHit;
   logic [31:0] rdMux;

   assign apbAccess = psel && penable && !ready_r;

   always_comb begin
      addrHit = 1'b1;
      rdMux   = '0;
      unique case (paddr)
         ADDR_CTRL:    rdMux = {29'h0, ctrl_r};
         ADDR_STATUS:  rdMux = {22'h0, errBit_r, 1'b0, 8'h00};
         ADDR_ALIAS:   rdMux = {16'h0, alias_r};
         ADDR_CAP0:    rdMux = {NUM_SYNC_MGR, NUM_MAP_UNIT, MAX_PDO_PER_DIR,
                                4'h0, DC_TIME_BITS,
                                ctrl_r[CTRL_EXT_FW] ? PD_BYTES_EXT : PD_BYTES_BASE};
         ADDR_CAP1:    rdMux = {ctrl_r[CTRL_EXT_FW] ? SYNC_MIN_US_EXT : SYNC_MIN_US_BASE,
                                ctrl_r[CTRL_EXT_FW] ? SYNC_MULT_EXT : SYNC_MULT_BASE,
                                SM_ROLE_INPD, SM_ROLE_OUTPD};
         ADDR_CAP2:    rdMux = {SAFETY_WD_MIN_MS, IDENT_FIELD_NUM, 3'h0, 1'b0,
                                MBX_SERVICES};
         ADDR_MBX_REQ: rdMux = '0;
         ADDR_MBX_RSP: rdMux = {30'h0, mbxRsp_r};
         ADDR_SLAVEST: rdMux = {22'h0, wdogTimeout, localDrop, warnLevel, cfgErr,
                                loadErr, commErr, slaveState};
         default:      addrHit = 1'b0;
      endcase
   end

   always_comb begin
      ctrl_nxt        = ctrl_r;
      alias_nxt       = alias_r;
      aliasLoaded_nxt = 1'b1;
      nvWr_nxt        = 1'b0;
      mbxRsp_nxt      = mbxRsp_r;
      errBit_nxt      = errBit_r;
      rdata_nxt       = rdata_r;
      ready_nxt       = apbAccess;
      slverr_nxt      = 1'b0;
      gridAlign_nxt   = ctrl_r[CTRL_SYNC_EN] && syncS2_r && !syncS3_r;
      if (!aliasLoaded_r) begin
         alias_nxt = aliasNvIn;
      end
      if (apbAccess) begin
         slverr_nxt = !addrHit;
         rdata_nxt  = pwrite ? 32'h0 : rdMux;
         if (pwrite) begin
            unique case (paddr)
               ADDR_CTRL: begin
                  ctrl_nxt = pwdata[2:0];
               end
               ADDR_STATUS: begin
                  if (pwdata[SST_WDOG]) begin
                     errBit_nxt = 1'b0;
                  end
               end
               ADDR_ALIAS: begin
                  alias_nxt = pwdata[15:0];
                  nvWr_nxt  = 1'b1;
               end
               ADDR_MBX_REQ: begin
                  // Bit 4 flags a whole-object complete access.
                  if (!pwdata[4] && (pwdata[3:0] == MBX_DOWNLOAD ||
                      pwdata[3:0] == MBX_UPLOAD || pwdata[3:0] == MBX_EMERGENCY)) begin
                     mbxRsp_nxt = MBX_RSP_OK;
                  end else begin
                     mbxRsp_nxt = MBX_RSP_UNSUP;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // Set wins over the software clear.
      if (localDrop) begin
         errBit_nxt = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_r        <= '0;
         alias_r       <= '0;
         aliasLoaded_r <= 1'b0;
         nvWr_r        <= 1'b0;
         mbxRsp_r      <= '0;
         errBit_r      <= 1'b0;
         rdata_r       <= '0;
         ready_r       <= 1'b0;
         slverr_r      <= 1'b0;
         gridAlign_r   <= 1'b0;
      end else begin
         ctrl_r        <= ctrl_nxt;
         alias_r       <= alias_nxt;
         aliasLoaded_r <= aliasLoaded_nxt;
         nvWr_r        <= nvWr_nxt;
         mbxRsp_r      <= mbxRsp_nxt;
         errBit_r      <= errBit_nxt;
         rdata_r       <= rdata_nxt;
         ready_r       <= ready_nxt;
         slverr_r      <= slverr_nxt;
         gridAlign_r   <= gridAlign_nxt;
      end
   end

   // Network status pattern selection, faults ahead of states.
   fbs_pat_e pat;
   always_comb begin
      pat = PAT_OFF;
      if (commErr) begin
         pat = PAT_R_ON;
      end else if (loadErr) begin
         pat = PAT_R_LOAD;
      end else if (cfgErr) begin
         pat = PAT_R_CFG;
      end else if (wdogTimeout) begin
         pat = PAT_R_DOUBLE;
      end else if (errBit_r || warnLevel) begin
         pat = PAT_R_SINGLE;
      end else if (slaveState == ST_OP) begin
         pat = PAT_G_ON;
      end else if (slaveState == ST_SAFEOP) begin
         pat = PAT_G_SAFEOP;
      end else if (slaveState == ST_PREOP) begin
         pat = PAT_G_FAST;
      end
   end

   fbs_pat_e     patLast_r, patLast_nxt;
   logic [CNT_W-1:0] slotCnt_r, slotCnt_nxt;
   logic [2:0]   slot_r, slot_nxt;
   logic         green_r, green_nxt, red_r, red_nxt;
   logic         fast;
   logic [2:0]   slots;
   logic         redOn, grnOn;

   always_comb begin
      fast  = (pat == PAT_G_FAST) || (pat == PAT_R_LOAD);
      slots = 3'h2;
      unique case (pat)
         PAT_G_SAFEOP: slots = 3'h6;
         PAT_R_SINGLE: slots = 3'h5;
         PAT_R_DOUBLE: slots = 3'h7;
         default:      slots = 3'h2;
      endcase
      slotCnt_nxt = slotCnt_r + 1'b1;
      slot_nxt    = slot_r;
      patLast_nxt = pat;
      if (pat != patLast_r) begin
         slotCnt_nxt = '0;
         slot_nxt    = '0;
      end else if (slotCnt_r == CNT_W'(fast ? FAST_CYC - 1 : SLOW_CYC - 1)) begin
         slotCnt_nxt = '0;
         slot_nxt    = (slot_r == slots - 3'h1) ? 3'h0 : slot_r + 3'h1;
      end
      redOn = 1'b0;
      grnOn = 1'b0;
      unique case (pat)
         PAT_OFF:      begin end
         PAT_G_FAST,
         PAT_G_SAFEOP: grnOn = (slot_nxt == 3'h0);
         PAT_G_ON:     grnOn = 1'b1;
         PAT_R_ON:     redOn = 1'b1;
         PAT_R_LOAD,
         PAT_R_CFG,
         PAT_R_SINGLE: redOn = (slot_nxt == 3'h0);
         PAT_R_DOUBLE: redOn = (slot_nxt == 3'h0) || (slot_nxt == 3'h2);
      endcase
      // Green and red both light in slot 0 of their pattern; only one colour is ever chosen.
      red_nxt   = redOn;
      green_nxt = grnOn && !redOn;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         patLast_r <= PAT_OFF;
         slotCnt_r <= '0;
         slot_r    <= '0;
         green_r   <= 1'b0;
         red_r     <= 1'b0;
      end else begin
         patLast_r <= patLast_nxt;
         slotCnt_r <= slotCnt_nxt;
         slot_r    <= slot_nxt;
         green_r   <= green_nxt;
         red_r     <= red_nxt;
      end
   end

   // Link LEDs; activity is stretched so short bursts still flicker visibly.
   logic [CNT_W-1:0] flick_r, flick_nxt;
   logic             flickPh_r, flickPh_nxt;
   logic [CNT_W-1:0] hold_r [PW];
   logic [CNT_W-1:0] hold_nxt [PW];
   logic [PW-1:0]    link_r, link_nxt;

   always_comb begin
      flick_nxt   = flick_r + 1'b1;
      flickPh_nxt = flickPh_r;
      if (flick_r == CNT_W'(FLICK_CYC - 1)) begin
         flick_nxt   = '0;
         flickPh_nxt = !flickPh_r;
      end
      for (int i = 0; i < PW; i++) begin
         hold_nxt[i] = (hold_r[i] != '0) ? hold_r[i] - 1'b1 : '0;
         if (actS2_r[i]) begin
            hold_nxt[i] = CNT_W'(ACT_HOLD_CYC);
         end
         link_nxt[i] = openS2_r[i] && ((hold_r[i] == '0) || flickPh_r);
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         flick_r   <= '0;
         flickPh_r <= 1'b0;
         link_r    <= '0;
         for (int i = 0; i < PW; i++) begin
            hold_r[i] <= '0;
         end
      end else begin
         flick_r   <= flick_nxt;
         flickPh_r <= flickPh_nxt;
         link_r    <= link_nxt;
         for (int i = 0; i < PW; i++) begin
            hold_r[i] <= hold_nxt[i];
         end
      end
   end

   assign pready        = ready_r;
   assign prdata        = rdata_r;
   assign pslverr       = slverr_r;
   assign aliasNvOut    = alias_r;
   assign aliasNvWrite  = nvWr_r;
   assign netLedGreen   = green_r;
   assign netLedRed     = red_r;
   assign linkLedGreen  = link_r;
   assign linkLedYellow = '0;
   assign errorBit      = errBit_r;
   assign gridAlign     = gridAlign_r;
endmodule : fbs_status_led
`default_nettype wire

// ===== fbs_status_led_props.sv
/*
 Checker for the status indication block: bus answer, refusal, LED and link relations.
 Assumes it sees only the top ports, attached by the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module fbs_status_led_props
   import fbs_pkg::*;
(
   // Clock and reset.
   input wire logic                 ref_clk,
   input wire logic                 nrst,
   // Bus.
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [7:0]           paddr,
   input wire logic                 pready,
   input wire logic [31:0]          prdata,
   input wire logic                 pslverr,
   // State and errors.
   input wire logic [3:0]           slaveState,
   input wire logic                 commErr,
   input wire logic                 loadErr,
   input wire logic                 cfgErr,
   input wire logic                 warnLevel,
   input wire logic                 wdogTimeout,
   input wire logic                 localDrop,
   // Pins and outputs.
   input wire logic [NUM_PORTS-1:0] portOpen,
   input wire logic                 syncPulse,
   input wire logic                 netLedGreen,
   input wire logic                 netLedRed,
   input wire logic [NUM_PORTS-1:0] linkLedGreen,
   input wire logic [NUM_PORTS-1:0] linkLedYellow,
   input wire logic                 errorBit,
   input wire logic                 gridAlign,
   input wire logic                 aliasNvWrite
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // A drop in the same cycle would raise the error bit, so it counts as noise too.
   wire quiet = !(commErr | loadErr | cfgErr | warnLevel | wdogTimeout | errorBit | localDrop);
   sequence s_access; psel && penable && !pready; endsequence
   sequence s_alias_wr; pready && pwrite && !pslverr && paddr == ADDR_ALIAS; endsequence
   chk_apb_answer: assert property (s_access |=> pready) else $error("no bus answer");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   chk_unmapped_err: assert property (pready |-> pslverr == (paddr > ADDR_SLAVEST
      || paddr[1:0] != 2'h0)) else $error("wrong error flag");
   chk_refused_data: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("refused read data");
   chk_alias_store: assert property (s_alias_wr |-> ##[0:2] aliasNvWrite)
      else $error("alias not stored");
   chk_yellow_unused: assert property (linkLedYellow == '0) else $error("yellow lit");
   chk_one_colour: assert property (!(netLedGreen && netLedRed))
      else $error("both colours lit");
   chk_init_dark: assert property (slaveState == ST_INIT && quiet [*2] |->
      !netLedGreen && !netLedRed) else $error("init not dark");
   chk_op_green: assert property (slaveState == ST_OP && quiet [*2] |-> netLedGreen)
      else $error("op not green");
   chk_fault_red: assert property (commErr [*2] |-> netLedRed && !netLedGreen)
      else $error("fault not red");
   chk_drop_sets: assert property (localDrop |-> ##[1:2] errorBit)
      else $error("error bit not set");
   chk_link_closed: assert property (!portOpen[0] [*4] |-> !linkLedGreen[0])
      else $error("closed port lit");
   chk_grid_cause: assert property (gridAlign |-> $past(syncPulse, 3))
      else $error("align without sync");
endmodule : fbs_status_led_props
bind fbs_status_led fbs_status_led_props i_fbs_status_led_props (.ref_clk(ref_clk),
   .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pready(pready), .prdata(prdata), .pslverr(pslverr), .slaveState(slaveState),
   .commErr(commErr), .loadErr(loadErr), .cfgErr(cfgErr), .warnLevel(warnLevel),
   .wdogTimeout(wdogTimeout), .localDrop(localDrop), .portOpen(portOpen),
   .syncPulse(syncPulse), .netLedGreen(netLedGreen), .netLedRed(netLedRed),
   .linkLedGreen(linkLedGreen), .linkLedYellow(linkLedYellow), .errorBit(errorBit),
   .gridAlign(gridAlign), .aliasNvWrite(aliasNvWrite));
`default_nettype wire

// ===== tb_fbs_status_led.sv
/*
 Self-checking bench of the status indication block over APB and its pins.
 Assumes the partner model for the alias store and sync pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_fbs_status_led;
   import fbs_pkg::*;
   logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic pready, pslverr, e, syncPulse, netLedGreen, netLedRed, errorBit, gridAlign;
   logic [3:0] slaveState = ST_INIT;
   logic commErr = 0, loadErr = 0, cfgErr = 0, warnLevel = 0, localDrop = 0;
   logic wdogTimeout = 0, aliasNvWrite;
   logic [NUM_PORTS-1:0] portOpen = '0, portActivity = '0, linkLedGreen, linkLedYellow;
   logic [15:0] aliasNvIn, aliasNvOut;
   int n_errors = 0, samples_checked = 0, cyc = 0;
   fbs_status_led i_fbs_status_led (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .slaveState, .commErr, .loadErr, .cfgErr,
      .warnLevel, .localDrop, .wdogTimeout, .portOpen, .portActivity, .syncPulse,
      .aliasNvIn, .aliasNvOut, .aliasNvWrite, .netLedGreen, .netLedRed, .linkLedGreen,
      .linkLedYellow, .errorBit, .gridAlign);
   fbs_fieldbus_partner i_fbs_fieldbus_partner (.ref_clk, .nrst, .aliasNvOut,
      .aliasNvWrite, .aliasNvIn, .syncPulse);
   initial forever #2 ref_clk = ~ref_clk;
   task automatic give_verdict();
      if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         give_verdict();
      end
   end
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wt(int n);
      repeat (n) @(posedge ref_clk);
   endtask : wt
   // Starts and ends on a rising edge; an idle cycle keeps psel from two updates at once.
   // The answer is taken at the rising edge where pready is seen high, then released.
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      penable <= 1'b0;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   task automatic t_caps();
      apb(0, ADDR_CTRL, 0); chk("ctrl", q, 32'h0);
      apb(0, ADDR_CAP0, 0); chk("cap0", q, 32'h4320_2020);
      apb(0, ADDR_CAP1, 0); chk("cap1", q[31:8], 24'h01f408);
      apb(0, ADDR_CAP2, 0); chk("cap2", q, 32'h0023_8607);
      apb(1, ADDR_CTRL, 32'h1);
      apb(0, ADDR_CAP0, 0); chk("cap0 ext", q[7:0], 8'h40);
      apb(0, ADDR_CAP1, 0); chk("cap1 ext", q[31:8], 24'h00fa04);
      apb(1, ADDR_CTRL, 32'h0);
   endtask : t_caps
   task automatic t_refuse();
      apb(0, 8'h40, 0); chk("unmapped err", e, 1); chk("unmapped data", q, 0);
      apb(1, 8'h42, 32'hffffffff); chk("unaligned err", e, 1);
      apb(1, ADDR_SLAVEST, 32'hffffffff);
      apb(0, ADDR_SLAVEST, 0); chk("live status", q, 32'h1);
   endtask : t_refuse
   task automatic t_mbx();
      for (int i = 0; i < 6; i++) begin
         apb(1, ADDR_MBX_REQ, 32'(i % 3 + 1) | (i > 2 ? 32'h10 : 32'h0));
         apb(0, ADDR_MBX_RSP, 0); chk("mbx rsp", q, i > 2 ? 32'h2 : 32'h1);
      end
   endtask : t_mbx
   task automatic t_leds();
      logic [10:0] tbl [10] = '{{4'h1, 5'h00, 2'h0}, {4'h2, 5'h00, 2'h1},
         {4'h4, 5'h00, 2'h1}, {4'h8, 5'h00, 2'h1}, {4'h8, 5'h02, 2'h2},
         {4'h8, 5'h01, 2'h2}, {4'h8, 5'h04, 2'h2}, {4'h1, 5'h08, 2'h2},
         {4'h8, 5'h18, 2'h2}, {4'h2, 5'h00, 2'h1}};
      foreach (tbl[i]) begin
         slaveState <= tbl[i][10:7];
         {commErr, loadErr, cfgErr, warnLevel, wdogTimeout} <= tbl[i][6:2];
         wt(3);
         chk("net led", {netLedRed, netLedGreen}, tbl[i][1:0]);
      end
   endtask : t_leds
   task automatic t_local();
      slaveState <= ST_OP; localDrop <= 1'b1;
      wt(1); localDrop <= 1'b0; wt(3);
      chk("error bit", errorBit, 1); chk("drop led", {netLedRed, netLedGreen}, 2'h2);
      apb(0, ADDR_STATUS, 0); chk("status bit", q[9], 1);
      apb(1, ADDR_STATUS, 32'h200); wt(3);
      chk("cleared", errorBit, 0); chk("op led", {netLedRed, netLedGreen}, 2'h1);
   endtask : t_local
   task automatic t_link();
      wt(5); chk("closed", linkLedGreen, 2'h0);
      portOpen <= 2'h3; wt(5); chk("open", linkLedGreen, 2'h3);
      portActivity <= 2'h1; wt(5); chk("idle port", linkLedGreen[1], 1);
      chk("yellow", linkLedYellow, 2'h0); portActivity <= 2'h0;
   endtask : t_link
   task automatic t_sync(logic en, int exp);
      int cnt = 0;
      apb(1, ADDR_CTRL, {30'h0, en, 1'b0});
      repeat (300) begin
         @(negedge ref_clk);
         if (gridAlign === 1'b1) cnt++;
      end
      @(posedge ref_clk);
      chk("grid pulses", cnt, exp);
   endtask : t_sync
   task automatic t_alias();
      apb(0, ADDR_ALIAS, 0); chk("alias load", q, 32'h5a3c);
      apb(1, ADDR_ALIAS, 32'h1234); wt(3);
      chk("nv copy", aliasNvIn, 16'h1234);
      nrst <= 1'b0; wt(3); nrst <= 1'b1; wt(2);
      apb(0, ADDR_ALIAS, 0); chk("alias kept", q, 32'h1234);
   endtask : t_alias
   initial begin
      wt(8);
      nrst <= 1'b1;
      wt(2);
      t_caps(); t_refuse(); t_mbx(); t_leds(); t_local(); t_link();
      t_sync(1, 3); t_sync(0, 0); t_alias();
      give_verdict();
   end
endmodule : tb_fbs_status_led
`default_nettype wire
